// [adc_cfg_pkg.sv]
// package for the gain and format configuration register bank
// assumes one 100 MHz clock and a plain strobe register port
package adc_cfg_pkg;

	localparam logic [7:0] gain_cfg_addr   = 8'h03;
	localparam logic [7:0] format_cfg_addr = 8'h04;
	localparam logic [7:0] opmode_cfg_addr = 8'h10;
	localparam logic [7:0] status_addr     = 8'h11;
	localparam logic [7:0] result_addr     = 8'h12;
	localparam logic [7:0] gain_cfg_rst    = 8'h8b;
	localparam logic [7:0] format_cfg_rst  = 8'h00;
	localparam logic [1:0] opmode_rst      = 2'h0;

	localparam int bias_msb    = 7;
	localparam int gain_msb    = 5;
	localparam int autozero_b  = 2;
	localparam int convmode_msb = 7;
	localparam int format_msb  = 5;
	localparam int crcfmt_b    = 3;
	localparam int crcen_b     = 2;
	localparam int offcal_b    = 1;
	localparam int gaincal_b   = 0;

	localparam logic [1:0] mode_convert  = 2'h3;
	localparam logic [1:0] mode_standby  = 2'h2;
	localparam logic [1:0] mode_shutdown = 2'h0;

	localparam logic [1:0] conv_continuous = 2'h3;
	localparam logic [1:0] conv_oneshot_sb = 2'h2;

	localparam logic [1:0] fmt_16     = 2'h0;
	localparam logic [1:0] fmt_32_left = 2'h1;
	localparam logic [1:0] fmt_32_sgn = 2'h2;
	localparam logic [1:0] fmt_32_channel_identifier = 2'h3;

	typedef struct packed {
		logic [1:0] bias_current_select;
		logic [2:0] gain_code;
		logic       input_autozero_enable;
		logic [1:0] reserved_ones;
	} gain_cfg_type;

	typedef struct packed {
		logic [1:0] conversion_mode_select;
		logic [1:0] output_format;
		logic       checksum_format;
		logic       read_checksum_enable;
		logic       offset_correction_enable;
		logic       gain_correction_enable;
	} format_cfg_type;

	typedef struct packed {
		logic [2:0] analog_gain_code;
		logic [1:0] digital_shift;
		logic       autozero;
		logic       double_time;
		logic       continuous;
		logic       offset_cal;
		logic       gain_cal;
		logic [1:0] bias;
		logic [1:0] format;
		logic       crc_wide;
		logic       crc_enable;
	} core_ctrl_type;

endpackage : adc_cfg_pkg

// [adc_result_formatter.sv]
// result path: corrections, clamping and output word formatting
// assumes a 17-bit signed raw result and 16-bit correction words
`timescale 1ns/1ps
`default_nettype none
module adc_result_formatter (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_valid,
	input  wire logic [16:0] i_raw,
	input  wire logic [3:0]  i_channel_identifier,
	input  wire logic [1:0]  i_digital_shift,
	input  wire logic        i_offset_cal,
	input  wire logic        i_gain_cal,
	input  wire logic [15:0] i_offset_word,
	input  wire logic [15:0] i_gain_word,
	input  wire logic [1:0]  i_format,
	output logic      [31:0] o_word,
	output logic             o_valid
);
	logic signed [19:0] shifted;
	logic signed [19:0] with_offset;
	logic signed [37:0] gain_product;
	logic signed [19:0] corrected;
	logic        [15:0] clamped16;
	logic        [16:0] overrange17;
	logic        [31:0] word_d;
	logic        [31:0] word_q;
	logic               valid_q;

	function automatic logic [16:0] sat17(input logic signed [19:0] v);
		if (v > 20'sd65535)
			return 17'h0ffff;
		else if (v < -20'sd65536)
			return 17'h10000;
		else
			return v[16:0];
	endfunction : sat17

	// upper gain codes get a digital x2 or x4 after the analog x16
	assign shifted = 20'(signed'(i_raw)) <<< i_digital_shift;
	assign with_offset = i_offset_cal ? shifted + 20'(signed'(i_offset_word)) : shifted;
	// gain word is unity at 0x8000, so the product keeps fifteen fraction bits
	assign gain_product = 38'(with_offset) * 38'(signed'({2'h0, i_gain_word}));
	assign corrected = i_gain_cal ? 20'(gain_product >>> 15) : with_offset;
	assign overrange17 = sat17(corrected);
	// 16-bit formats lock at full scale and cannot show overrange
	assign clamped16 = (corrected > 20'sd32767) ? 16'hffff :
		(corrected < -20'sd32768) ? 16'h8000 : corrected[15:0];
	assign word_d = (i_format == adc_cfg_pkg::fmt_16)      ? {16'h0000, clamped16} :
		(i_format == adc_cfg_pkg::fmt_32_left) ? {clamped16, 16'h0000} :
		(i_format == adc_cfg_pkg::fmt_32_sgn)  ? {{15{overrange17[16]}}, overrange17} :
		{i_channel_identifier, {11{overrange17[16]}}, overrange17};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			word_q  <= 32'h0;
			valid_q <= 1'b0;
		end else begin
			if (i_valid)
				word_q <= word_d;
			valid_q <= i_valid;
		end
	end

	assign o_word  = word_q;
	assign o_valid = valid_q;
endmodule : adc_result_formatter
`default_nettype wire

// [adc_gain_format_config_regs.sv]
// gain and output-format configuration registers of the converter core
// assumes a host register port on i_ref_clk and a converter core that pulses done
// Summary of operation
// - bias field bits 7-6 scale current: 11 x2, 10 x1 reset, 01 x0.66, 00 x0.5
// - gain field maps 000 1/3, 001 unity reset, up to 111 x64
// - gain codes 110 and 111 use analog x16 then digital x2 or x4
// - autozero bit enables input autozeroing and doubles conversion time
// - with autozero, continuous requests run as back-to-back single conversions
// - conversion mode 11 converts or scans continuously
// - conversion mode 10 does one conversion then sets operating mode standby
// - conversion mode 0x does one conversion then sets operating mode shutdown
// - format 00 gives 16-bit word clamped at 0xffff or 0x8000
// - format 01 gives result left justified above sixteen zero bits
// - format 10 gives sixteen sign bits above the result, overrange allowed
// - format 11 gives channel id, twelve sign bits, then the result
// - checksum format bit selects 16-bit or 32-bit read checksum
// - read checksum enable appends checksum to reads, config checksum unaffected
// - offset correction enable applies stored offset, cleared at reset
// - bit 0 gain correction enable is read-only to the port, so it stays cleared from reset
// - operating mode 11 converting, 10 standby, 0x shutdown, 00 at reset
// - presented result already includes enabled offset and gain corrections
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_gain_format_config_regs (
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_conv_done,
	input  wire logic [16:0] i_raw_result,
	input  wire logic [3:0]  i_channel_identifier,
	input  wire logic [15:0] i_offset_word,
	input  wire logic [15:0] i_gain_word,
	output logic             o_conv_start,
	output adc_cfg_pkg::core_ctrl_type o_ctrl,
	output logic [1:0]       o_operating_mode,
	output logic [31:0]      o_result_word,
	output logic             o_result_valid
);
	typedef enum logic [1:0] {idle_st, busy_st, restart_st} conv_state_type;

	adc_cfg_pkg::gain_cfg_type   gain_q;
	adc_cfg_pkg::gain_cfg_type   gain_d;
	adc_cfg_pkg::format_cfg_type fmt_q;
	adc_cfg_pkg::format_cfg_type fmt_d;
	adc_cfg_pkg::core_ctrl_type  ctrl_d;
	adc_cfg_pkg::core_ctrl_type  ctrl_q;
	conv_state_type              state_q;
	conv_state_type              state_d;
	logic [1:0]                  mode_q;
	logic [1:0]                  mode_d;
	logic [31:0]                 rdata_d;
	logic [31:0]                 rdata_q;
	logic                        start_d;
	logic                        start_q;
	logic                        wr_gain;
	logic                        wr_fmt;
	logic                        wr_mode;
	logic                        converting;
	logic                        autozero;
	logic                        continuous_run;
	logic                        oneshot_end;
	logic [1:0]                  end_mode;
	logic [1:0]                  dshift;
	logic [2:0]                  analog_code;
	logic [31:0]                 result_word;
	logic                        result_valid;
	logic [3:0]                  conv_count_q;

	function automatic logic [31:0] pad8(input logic [7:0] v);
		return {24'h0, v};
	endfunction : pad8

	assign wr_gain = i_wr && (i_addr == adc_cfg_pkg::gain_cfg_addr);
	assign wr_fmt  = i_wr && (i_addr == adc_cfg_pkg::format_cfg_addr);
	assign wr_mode = i_wr && (i_addr == adc_cfg_pkg::opmode_cfg_addr);

	// reserved low bits are stored as written; software owns keeping them at 11
	assign gain_d = wr_gain ? adc_cfg_pkg::gain_cfg_type'(i_wdata) : gain_q;
	// bit 0 is read-only to the port, so a write keeps the stored gain enable
	assign fmt_d = wr_fmt ? adc_cfg_pkg::format_cfg_type'({i_wdata[7:1], fmt_q.gain_correction_enable}) : fmt_q;

	assign converting = (mode_q == adc_cfg_pkg::mode_convert);
	assign autozero   = gain_q.input_autozero_enable;
	// autozero forbids free running, so continuous becomes repeated one-shots
	assign continuous_run = (fmt_q.conversion_mode_select == adc_cfg_pkg::conv_continuous) && !autozero;
	assign oneshot_end = (state_q == busy_st) && i_conv_done &&
		(fmt_q.conversion_mode_select != adc_cfg_pkg::conv_continuous);
	assign end_mode = (fmt_q.conversion_mode_select == adc_cfg_pkg::conv_oneshot_sb) ?
		adc_cfg_pkg::mode_standby : adc_cfg_pkg::mode_shutdown;

	// the hardware update wins over a software write in the same cycle
	assign mode_d = oneshot_end ? end_mode :
		wr_mode ? i_wdata[1:0] : mode_q;

	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		unique case (state_q)
			idle_st: begin
				if (converting) begin
					state_d = busy_st;
					start_d = 1'b1;
				end
			end
			busy_st: begin
				if (!converting)
					state_d = idle_st;
				else if (i_conv_done) begin
					if (fmt_q.conversion_mode_select != adc_cfg_pkg::conv_continuous)
						state_d = idle_st;
					else if (!continuous_run)
						state_d = restart_st;
				end
			end
			restart_st: begin
				state_d = converting ? busy_st : idle_st;
				start_d = converting;
			end
		endcase
	end

	// top two codes run the analog stage at x16 and finish digitally
	assign analog_code = (gain_q.gain_code[2:1] == 2'h3) ? 3'h5 : gain_q.gain_code;
	assign dshift = (gain_q.gain_code == 3'h7) ? 2'h2 :
		(gain_q.gain_code == 3'h6) ? 2'h1 : 2'h0;

	assign ctrl_d = '{analog_gain_code: analog_code,
		digital_shift: dshift,
		autozero:    autozero,
		double_time: autozero,
		continuous:  continuous_run,
		offset_cal:  fmt_q.offset_correction_enable,
		gain_cal:    fmt_q.gain_correction_enable,
		bias:        gain_q.bias_current_select,
		format:      fmt_q.output_format,
		crc_wide:    fmt_q.checksum_format,
		crc_enable:  fmt_q.read_checksum_enable};

	adc_result_formatter u_adc_result_formatter (
		.i_ref_clk            (i_ref_clk),
		.i_arst_n             (i_arst_n),
		.i_valid              (i_conv_done && (state_q == busy_st)),
		.i_raw                (i_raw_result),
		.i_channel_identifier (i_channel_identifier),
		.i_digital_shift      (dshift),
		.i_offset_cal         (fmt_q.offset_correction_enable),
		.i_gain_cal           (fmt_q.gain_correction_enable),
		.i_offset_word        (i_offset_word),
		.i_gain_word          (i_gain_word),
		.i_format             (fmt_q.output_format),
		.o_word               (result_word),
		.o_valid              (result_valid)
	);

	assign rdata_d = !i_rd ? 32'h0 :
		(i_addr == adc_cfg_pkg::gain_cfg_addr)   ? pad8(gain_q) :
		(i_addr == adc_cfg_pkg::format_cfg_addr) ? pad8(fmt_q) :
		(i_addr == adc_cfg_pkg::opmode_cfg_addr) ? {30'h0, mode_q} :
		(i_addr == adc_cfg_pkg::status_addr)     ? {26'h0, conv_count_q, state_q} :
		(i_addr == adc_cfg_pkg::result_addr)     ? result_word : 32'h0;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gain_q  <= adc_cfg_pkg::gain_cfg_rst;
			fmt_q   <= adc_cfg_pkg::format_cfg_rst;
			mode_q  <= adc_cfg_pkg::opmode_rst;
			state_q <= idle_st;
			start_q <= 1'b0;
			ctrl_q  <= '0;
			rdata_q <= 32'h0;
		end else begin
			gain_q  <= gain_d;
			fmt_q   <= fmt_d;
			mode_q  <= mode_d;
			state_q <= state_d;
			start_q <= start_d;
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// diagnostic count of finished conversions, wraps freely
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			conv_count_q <= 4'h0;
		else if (result_valid)
			conv_count_q <= conv_count_q + 4'h1;
	end

	assign o_rdata          = rdata_q;
	assign o_conv_start     = start_q;
	assign o_ctrl           = ctrl_q;
	assign o_operating_mode = mode_q;
	assign o_result_word    = result_word;
	assign o_result_valid   = result_valid;
endmodule : adc_gain_format_config_regs
`default_nettype wire

// [adc_gain_format_config_regs_monitor.sv]
// concurrent checks on the ports of the gain and format register bank
// assumes one clock domain; o_ctrl lags a register write by two cycles
`timescale 1ns/1ps
`default_nettype none
module adc_gain_format_config_regs_monitor (
	input wire logic        i_ref_clk,
	input wire logic        i_arst_n,
	input wire logic [7:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_conv_done,
	input wire logic [3:0]  i_channel_identifier,
	input wire logic        o_conv_start,
	input wire adc_cfg_pkg::core_ctrl_type o_ctrl,
	input wire logic [1:0]  o_operating_mode,
	input wire logic [31:0] o_result_word,
	input wire logic        o_result_valid
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	// a second write right behind the first would move the decoded value, so it is excluded
	sequence s_gain_wr; i_wr && i_addr == adc_cfg_pkg::gain_cfg_addr ##1 !i_wr; endsequence
	sequence s_fmt_wr; i_wr && i_addr == adc_cfg_pkg::format_cfg_addr ##1 !i_wr; endsequence
	property p_bias; s_gain_wr |=> o_ctrl.bias == $past(i_wdata[7:6], 2); endproperty
	a_bias: assert property (p_bias) else $error("bias decode wrong");
	property p_gain;
		s_gain_wr |=> o_ctrl.analog_gain_code == (($past(i_wdata[5:3], 2) > 3'h5) ? 3'h5 : $past(i_wdata[5:3], 2))
			&& o_ctrl.digital_shift == (($past(i_wdata[5:3], 2) == 3'h7) ? 2'h2
			: ($past(i_wdata[5:3], 2) == 3'h6) ? 2'h1 : 2'h0);
	endproperty
	a_gain: assert property (p_gain) else $error("gain decode wrong");
	property p_az; s_gain_wr |=> o_ctrl.autozero == $past(i_wdata[2], 2) && o_ctrl.double_time == o_ctrl.autozero;
	endproperty
	a_az: assert property (p_az) else $error("autozero decode wrong");
	property p_fmt;
		s_fmt_wr |=> o_ctrl.format == $past(i_wdata[5:4], 2) && o_ctrl.crc_wide == $past(i_wdata[3], 2)
			&& o_ctrl.crc_enable == $past(i_wdata[2], 2) && o_ctrl.offset_cal == $past(i_wdata[1], 2);
	endproperty
	a_fmt: assert property (p_fmt) else $error("format decode wrong");
	property p_gaincal; !o_ctrl.gain_cal; endproperty
	a_gaincal: assert property (p_gaincal) else $error("gain correction set");
	property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_valid; o_result_valid |-> $past(i_conv_done); endproperty
	a_valid: assert property (p_valid) else $error("result valid without done");
	property p_start; o_conv_start |-> o_operating_mode == adc_cfg_pkg::mode_convert; endproperty
	a_start: assert property (p_start) else $error("start outside convert mode");
	property p_out16; o_result_valid && o_ctrl.format == adc_cfg_pkg::fmt_16 |-> o_result_word[31:16] == 16'h0;
	endproperty
	a_out16: assert property (p_out16) else $error("16-bit word has upper bits");
	property p_outl; o_result_valid && o_ctrl.format == adc_cfg_pkg::fmt_32_left |-> o_result_word[15:0] == 16'h0;
	endproperty
	a_outl: assert property (p_outl) else $error("left word low half not zero");
	property p_outs; o_result_valid && o_ctrl.format == adc_cfg_pkg::fmt_32_sgn
		|-> o_result_word[31:17] == {15{o_result_word[16]}}; endproperty
	a_outs: assert property (p_outs) else $error("sign extension wrong");
	property p_outc; o_result_valid && o_ctrl.format == adc_cfg_pkg::fmt_32_channel_identifier
		|-> o_result_word[27:17] == {11{o_result_word[16]}} && o_result_word[31:28] == $past(i_channel_identifier);
	endproperty
	a_outc: assert property (p_outc) else $error("channel word wrong");
endmodule : adc_gain_format_config_regs_monitor
bind adc_gain_format_config_regs adc_gain_format_config_regs_monitor u_adc_gain_format_config_regs_monitor (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_conv_done(i_conv_done), .i_channel_identifier(i_channel_identifier),
	.o_conv_start(o_conv_start), .o_ctrl(o_ctrl), .o_operating_mode(o_operating_mode),
	.o_result_word(o_result_word), .o_result_valid(o_result_valid));
`default_nettype wire

// [adc_gain_format_config_regs_test.sv]
// self-checking bench for the gain and format configuration registers
// assumes the design and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define check_eq(n, e, g) compare(n, 32'(e), 32'(g))
module adc_gain_format_config_regs_test;
	logic                       ref_clk = 1'b0;
	logic                       arst_n = 1'b0;
	logic                       wr = 1'b0;
	logic                       rd = 1'b0;
	logic                       done = 1'b0;
	logic [7:0]                 addr = 8'h00;
	logic [7:0]                 wdata = 8'h00;
	logic [16:0]                raw = 17'h0;
	logic [3:0]                 chan_id = 4'h5;
	logic [31:0]                rdata;
	logic [31:0]                res_word;
	logic                       conv_start;
	logic                       res_valid;
	adc_cfg_pkg::core_ctrl_type ctrl;
	logic [1:0]                 op_mode;
	int                         mismatches = 0;
	int                         samples_checked = 0;
	int                         cycles = 0;
	int                         n;
	// offset word is nonzero throughout so a leak of the correction shows in every result
	adc_gain_format_config_regs u_adc_gain_format_config_regs (
		.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_conv_done(done), .i_raw_result(raw), .i_channel_identifier(chan_id),
		.i_offset_word(16'h0010), .i_gain_word(16'h8000), .o_conv_start(conv_start), .o_ctrl(ctrl),
		.o_operating_mode(op_mode), .o_result_word(res_word), .o_result_valid(res_valid));
	initial forever #5 ref_clk = ~ref_clk;
	task close_out;
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task compare(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : compare
	task reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : reg_wr
	task read_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		`check_eq(name, exp, rdata);
	endtask : read_chk
	task wait_start;
		#1;
		for (n = 0; n < 20 && conv_start !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		`check_eq("conv_start", 1'b1, conv_start);
	endtask : wait_start
	task pulse_done(input logic [16:0] r);
		@(posedge ref_clk);
		done <= 1'b1;
		raw <= r;
		@(posedge ref_clk);
		done <= 1'b0;
		#1;
	endtask : pulse_done
	task convert(input logic [7:0] fmt, input logic [16:0] r, input logic [31:0] exp, input logic [1:0] mode);
		reg_wr(adc_cfg_pkg::format_cfg_addr, fmt);
		reg_wr(adc_cfg_pkg::opmode_cfg_addr, 8'h03);
		wait_start;
		pulse_done(r);
		`check_eq("result_valid", 1'b1, res_valid);
		`check_eq("result_word", exp, res_word);
		read_chk("operating_mode", adc_cfg_pkg::opmode_cfg_addr, 32'(mode));
		read_chk("result_reg", adc_cfg_pkg::result_addr, exp);
	endtask : convert
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			close_out;
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		read_chk("gain_rst", adc_cfg_pkg::gain_cfg_addr, 32'h8b);
		read_chk("format_rst", adc_cfg_pkg::format_cfg_addr, 32'h00);
		read_chk("mode_rst", adc_cfg_pkg::opmode_cfg_addr, 32'h00);
		read_chk("unmapped", 8'h07, 32'h00);
		for (int i = 0; i < 8; i++) begin
			reg_wr(adc_cfg_pkg::gain_cfg_addr, {i[1:0], i[2:0], i[0], 2'b11});
			read_chk("gain_rw", adc_cfg_pkg::gain_cfg_addr, 32'({i[1:0], i[2:0], i[0], 2'b11}));
		end
		reg_wr(adc_cfg_pkg::format_cfg_addr, 8'hff);
		read_chk("format_ro", adc_cfg_pkg::format_cfg_addr, 32'hfe);
		reg_wr(adc_cfg_pkg::gain_cfg_addr, 8'h8b);
		convert(8'h00, 17'h1fffe, 32'h0000fffe, 2'h0);
		convert(8'h90, 17'h00123, 32'h01230000, 2'h2);
		convert(8'h20, 17'h08000, 32'h00008000, 2'h0);
		convert(8'h30, 17'h1fffe, 32'h5ffffffe, 2'h0);
		@(posedge ref_clk);
		chan_id <= 4'ha;
		convert(8'h30, 17'h00001, 32'ha0000001, 2'h0);
		convert(8'h02, 17'h00100, 32'h00000110, 2'h0);
		reg_wr(adc_cfg_pkg::gain_cfg_addr, 8'hb3);
		convert(8'h20, 17'h00100, 32'h00000200, 2'h0);
		reg_wr(adc_cfg_pkg::gain_cfg_addr, 8'hbb);
		convert(8'h20, 17'h00100, 32'h00000400, 2'h0);
		// free-running continuous mode keeps converting with no fresh start pulse
		reg_wr(adc_cfg_pkg::gain_cfg_addr, 8'h8b);
		reg_wr(adc_cfg_pkg::format_cfg_addr, 8'hc0);
		reg_wr(adc_cfg_pkg::opmode_cfg_addr, 8'h03);
		wait_start;
		`check_eq("ctrl_continuous", 1'b1, ctrl.continuous);
		`check_eq("op_mode", 2'h3, op_mode);
		pulse_done(17'h00042);
		`check_eq("result_cont", 32'h00000042, res_word);
		repeat (3) @(posedge ref_clk);
		#1;
		`check_eq("no_restart", 1'b0, conv_start);
		read_chk("mode_free", adc_cfg_pkg::opmode_cfg_addr, 32'h03);
		reg_wr(adc_cfg_pkg::opmode_cfg_addr, 8'h00);
		// continuous request under autozero must restart on its own after each result
		reg_wr(adc_cfg_pkg::gain_cfg_addr, 8'h8f);
		reg_wr(adc_cfg_pkg::format_cfg_addr, 8'hc0);
		reg_wr(adc_cfg_pkg::opmode_cfg_addr, 8'h03);
		wait_start;
		pulse_done(17'h00042);
		wait_start;
		read_chk("mode_cont", adc_cfg_pkg::opmode_cfg_addr, 32'h03);
		reg_wr(adc_cfg_pkg::opmode_cfg_addr, 8'h00);
		read_chk("mode_stop", adc_cfg_pkg::opmode_cfg_addr, 32'h00);
		// ten results so far, machine idle
		read_chk("status", adc_cfg_pkg::status_addr, 32'h00000028);
		close_out;
	end
endmodule : adc_gain_format_config_regs_test
`default_nettype wire
